/* common/iesm_pkg.sv */
// Package for the internal error status and mask register bank.
// Assumes a 32-bit register port with word-aligned byte offsets.
package iesm_pkg;
  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 32;
  localparam int          NUM_EVT     = 19;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL    = 12'h480;
  localparam logic [11:0] OFF_STATUS  = 12'h484;
  localparam logic [11:0] OFF_MASK    = 12'h488;
  localparam logic [11:0] OFF_SEV     = 12'h48C;
  localparam logic [11:0] OFF_PENDING = 12'h490;
  localparam logic [11:0] OFF_REPORT  = 12'h494;
  // Reset values
  localparam logic [31:0] RST_STATUS  = 32'h0000_0000;
  localparam logic [31:0] RST_MASK    = 32'h0000_0000;
  localparam logic [31:0] RST_SEV     = 32'h0000_0011;
  localparam logic [31:0] RST_CTRL    = 32'h0000_0001;
  // Implemented bits: 0..2 and 4..18; bit 3 and 19..31 reserved
  localparam logic [31:0] IMPL_MASK   = 32'h0007_FFF7;
  localparam logic [31:0] CTRL_IMPL   = 32'h0000_0001;
  // Control field position
  localparam int          CTRL_EN_BIT = 0;
  // Status bit positions
  localparam int          B_IN_P_TO   = 0;
  localparam int          B_IN_NP_TO  = 1;
  localparam int          B_IN_C_TO   = 2;
  localparam int          B_EG_P_TO   = 4;
  localparam int          B_EG_NP_TO  = 5;
  localparam int          B_EG_C_TO   = 6;
  localparam int          B_IN_D_SBE  = 7;
  localparam int          B_IN_D_DBE  = 8;
  localparam int          B_IN_C_SBE  = 9;
  localparam int          B_IN_C_DBE  = 10;
  localparam int          B_EG_D_SBE  = 11;
  localparam int          B_EG_D_DBE  = 12;
  localparam int          B_EG_C_SBE  = 13;
  localparam int          B_EG_C_DBE  = 14;
  localparam int          B_E2E_PAR   = 15;
  localparam int          B_UNREL     = 16;
  localparam int          B_RP_C_SBE  = 17;
  localparam int          B_RP_C_DBE  = 18;
endpackage

/* hw/iesm_w1c_bank.sv */
// Sticky write-one-to-clear status bank for internal error events.
// Assumes event pulses and write strobe are synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module iesm_w1c_bank (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [31:0] set_vec,
  input  wire logic        clr_we,
  input  wire logic [31:0] clr_data,
  output logic      [31:0] status
);
  import iesm_pkg::*;
  logic [31:0] status_q;
  logic [31:0] status_d;

  // Set wins over a same-cycle clear so no event is lost
  assign status_d = ((status_q & ~(clr_we ? clr_data : 32'h0000_0000)) | set_vec)
                    & IMPL_MASK;
  assign status   = status_q;

  // Status register
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end
endmodule
`default_nettype wire

/* hw/iesm_report.sv */
// Internal error report generator: mask, enable and severity split.
// Assumes all inputs come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module iesm_report (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [31:0] status,
  input  wire logic [31:0] mask,
  input  wire logic [31:0] sev,
  input  wire logic        enable,
  output logic      [31:0] pending,
  output logic             uncorr,
  output logic             corr
);
  import iesm_pkg::*;
  logic uncorr_q;
  logic corr_q;
  logic uncorr_d;
  logic corr_d;

  // RQ11 mask gates pending
  // Mask hides a bit from reporting only
  assign pending  = status & ~mask & IMPL_MASK;
  // RQ13 enable gates reports
  assign uncorr_d = enable & |(pending & sev);
  assign corr_d   = enable & |(pending & ~sev);
  assign uncorr   = uncorr_q;
  assign corr     = corr_q;

  // RQ16 report re-evaluated
  // Registered report levels, re-evaluated every cycle, so a clear drops them
  always_ff @(posedge clk) begin
    if (rst) begin
      uncorr_q <= 1'b0;
      corr_q   <= 1'b0;
    end else begin
      uncorr_q <= uncorr_d;
      corr_q   <= corr_d;
    end
  end
endmodule
`default_nettype wire

/* hw/iesm_top.sv */
// Internal error status and mask register bank of one switch port.
// Assumes event inputs are one-cycle or level signals on CLK_SYS and
// a simple register port with read data one cycle after the strobe.
//
// Function
// RQ1 - Ingress posted, non-posted, completion time-outs set bits 0, 1, 2.
// RQ2 - Egress posted, non-posted, completion time-outs set bits 4, 5, 6.
// RQ3 - Corrected single-bit error in ingress data RAM sets bit 7.
// RQ4 - Double-bit error in ingress data RAM sets bit 8.
// RQ5 - Ingress control RAM single and double-bit errors set bits 9, 10.
// RQ6 - Egress data RAM single and double-bit errors set bits 11, 12.
// RQ7 - Egress control RAM single and double-bit errors set bits 13, 14.
// RQ8 - End-to-end data path parity error sets bit 15.
// RQ9 - Rising unreliable-link flag sets bit 16.
// RQ10 - Replay control RAM single and double-bit errors set bits 17, 18.
// RQ11 - Mask bit one blocks reporting of its status bit; resets zero.
// RQ12 - Status records events regardless of mask.
// RQ13 - Reporting only while enable bit is one; enable resets to one.
// RQ14 - Severity one reports uncorrectable, zero reports correctable.
// RQ15 - Reserved bits 3 and 19..31 read zero, ignore writes.
// RQ16 - Report follows any set unmasked bit, updated after each clear.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module iesm_top (
  input  wire logic                       CLK_SYS,
  input  wire logic                       RESET,
  input  wire logic [iesm_pkg::ADDR_W-1:0] REG_ADDR,
  input  wire logic [iesm_pkg::DATA_W-1:0] REG_WDATA,
  input  wire logic                       REG_WR,
  input  wire logic                       REG_RD,
  output logic      [iesm_pkg::DATA_W-1:0] REG_RDATA,
  input  wire logic                       INGRESS_POSTED_TIMEOUT,
  input  wire logic                       INGRESS_NONPOSTED_TIMEOUT,
  input  wire logic                       INGRESS_COMPLETION_TIMEOUT,
  input  wire logic                       EGRESS_POSTED_TIMEOUT,
  input  wire logic                       EGRESS_NONPOSTED_TIMEOUT,
  input  wire logic                       EGRESS_COMPLETION_TIMEOUT,
  input  wire logic                       INGRESS_DATA_SINGLE_ERR,
  input  wire logic                       INGRESS_DATA_DOUBLE_ERR,
  input  wire logic                       INGRESS_CTRL_SINGLE_ERR,
  input  wire logic                       INGRESS_CTRL_DOUBLE_ERR,
  input  wire logic                       EGRESS_DATA_SINGLE_ERR,
  input  wire logic                       EGRESS_DATA_DOUBLE_ERR,
  input  wire logic                       EGRESS_CTRL_SINGLE_ERR,
  input  wire logic                       EGRESS_CTRL_DOUBLE_ERR,
  input  wire logic                       END_TO_END_PARITY_ERR,
  input  wire logic                       UNRELIABLE_LINK_FLAG,
  input  wire logic                       REPLAY_CTRL_SINGLE_ERR,
  input  wire logic                       REPLAY_CTRL_DOUBLE_ERR,
  output logic                            REPORT_UNCORRECTABLE,
  output logic                            REPORT_CORRECTABLE,
  output logic                            IRQ
);
  import iesm_pkg::*;

  // Register file state
  logic [31:0] mask_q;
  logic [31:0] sev_q;
  logic [31:0] ctrl_q;
  logic [31:0] rdata_q;
  logic        unrel_q;
  logic [31:0] status;
  logic [31:0] pending;
  logic [31:0] set_vec;
  logic [31:0] rdata_d;
  logic        unrel_rise;
  logic        report_en;

  // Address decode
  wire hit_ctrl   = (REG_ADDR == OFF_CTRL);
  wire hit_status = (REG_ADDR == OFF_STATUS);
  wire hit_mask   = (REG_ADDR == OFF_MASK);
  wire hit_sev    = (REG_ADDR == OFF_SEV);
  wire hit_pend   = (REG_ADDR == OFF_PENDING);
  wire hit_rep    = (REG_ADDR == OFF_REPORT);
  wire wr_ctrl    = REG_WR & hit_ctrl;
  wire wr_status  = REG_WR & hit_status;
  wire wr_mask    = REG_WR & hit_mask;
  wire wr_sev     = REG_WR & hit_sev;

  // RQ9 rising flag
  // Only the rising edge of the unreliable flag records an event
  assign unrel_rise = UNRELIABLE_LINK_FLAG & ~unrel_q;

  // RQ1 ingress time-outs
  // Event vector; each input lands on its own status bit
  always_comb begin
    set_vec             = 32'h0000_0000;
    set_vec[B_IN_P_TO]  = INGRESS_POSTED_TIMEOUT;
    set_vec[B_IN_NP_TO] = INGRESS_NONPOSTED_TIMEOUT;
    set_vec[B_IN_C_TO]  = INGRESS_COMPLETION_TIMEOUT;
    // RQ2 egress time-outs
    set_vec[B_EG_P_TO]  = EGRESS_POSTED_TIMEOUT;
    set_vec[B_EG_NP_TO] = EGRESS_NONPOSTED_TIMEOUT;
    set_vec[B_EG_C_TO]  = EGRESS_COMPLETION_TIMEOUT;
    // RQ3 ingress data single
    set_vec[B_IN_D_SBE] = INGRESS_DATA_SINGLE_ERR;
    // RQ4 ingress data double
    set_vec[B_IN_D_DBE] = INGRESS_DATA_DOUBLE_ERR;
    // RQ5 ingress control RAM
    set_vec[B_IN_C_SBE] = INGRESS_CTRL_SINGLE_ERR;
    set_vec[B_IN_C_DBE] = INGRESS_CTRL_DOUBLE_ERR;
    // RQ6 egress data RAM
    set_vec[B_EG_D_SBE] = EGRESS_DATA_SINGLE_ERR;
    set_vec[B_EG_D_DBE] = EGRESS_DATA_DOUBLE_ERR;
    // RQ7 egress control RAM
    set_vec[B_EG_C_SBE] = EGRESS_CTRL_SINGLE_ERR;
    set_vec[B_EG_C_DBE] = EGRESS_CTRL_DOUBLE_ERR;
    // RQ8 parity error
    set_vec[B_E2E_PAR]  = END_TO_END_PARITY_ERR;
    // RQ9 unreliable link
    set_vec[B_UNREL]    = unrel_rise;
    // RQ10 replay control RAM
    set_vec[B_RP_C_SBE] = REPLAY_CTRL_SINGLE_ERR;
    set_vec[B_RP_C_DBE] = REPLAY_CTRL_DOUBLE_ERR;
  end

  // RQ12 status independent of mask
  // The bank never sees the mask, so masking cannot alter status
  iesm_w1c_bank u_bank (
    .clk      (CLK_SYS),
    .rst      (RESET),
    .set_vec  (set_vec),
    .clr_we   (wr_status),
    .clr_data (REG_WDATA),
    .status   (status)
  );

  assign report_en = ctrl_q[CTRL_EN_BIT];

  // RQ11 mask gates reporting
  // RQ14 severity split
  iesm_report u_report (
    .clk     (CLK_SYS),
    .rst     (RESET),
    .status  (status),
    .mask    (mask_q),
    .sev     (sev_q),
    .enable  (report_en),
    .pending (pending),
    .uncorr  (REPORT_UNCORRECTABLE),
    .corr    (REPORT_CORRECTABLE)
  );

  // Interrupt follows any unmasked status bit, regardless of enable
  assign IRQ = |pending;

  // RQ15 reserved bits masked
  // Writable registers; reserved bits never store a value
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      mask_q  <= RST_MASK;
      sev_q   <= RST_SEV;
      ctrl_q  <= RST_CTRL;
      unrel_q <= 1'b0;
    end else begin
      unrel_q <= UNRELIABLE_LINK_FLAG;
      if (wr_mask) begin
        mask_q <= REG_WDATA & IMPL_MASK;
      end
      if (wr_sev) begin
        sev_q <= REG_WDATA & IMPL_MASK;
      end
      // RQ13 enable register
      if (wr_ctrl) begin
        ctrl_q <= REG_WDATA & CTRL_IMPL;
      end
    end
  end

  // Read mux; unmapped offsets read zero
  assign rdata_d = !REG_RD    ? 32'h0000_0000 :
                   hit_ctrl   ? ctrl_q :
                   hit_status ? status :
                   hit_mask   ? mask_q :
                   hit_sev    ? sev_q :
                   hit_pend   ? pending :
                   hit_rep    ? {30'h0000_0000, REPORT_CORRECTABLE, REPORT_UNCORRECTABLE} :
                   32'h0000_0000;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign REG_RDATA = rdata_q;

  // Assertions
  // RQ1 bit 0 set by event
  a_ingress_p_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ1
    INGRESS_POSTED_TIMEOUT |=> status[B_IN_P_TO])
    else $error("ingress posted time-out not recorded");

  // RQ2 egress completion bit
  a_egress_c_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ2
    EGRESS_COMPLETION_TIMEOUT |=> status[B_EG_C_TO])
    else $error("egress completion time-out not recorded");

  // RQ3 ingress data single
  a_in_dsbe_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ3
    INGRESS_DATA_SINGLE_ERR |=> status[B_IN_D_SBE])
    else $error("ingress data single error not recorded");

  // RQ4 ingress data double
  a_in_ddbe_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ4
    INGRESS_DATA_DOUBLE_ERR |=> status[B_IN_D_DBE])
    else $error("ingress data double error not recorded");

  // RQ5 ingress control double
  a_in_cdbe_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ5
    INGRESS_CTRL_DOUBLE_ERR |=> status[B_IN_C_DBE])
    else $error("ingress control double error not recorded");

  // RQ6 egress data single
  a_eg_dsbe_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ6
    EGRESS_DATA_SINGLE_ERR |=> status[B_EG_D_SBE])
    else $error("egress data single error not recorded");

  // RQ7 egress control single
  a_eg_csbe_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ7
    EGRESS_CTRL_SINGLE_ERR |=> status[B_EG_C_SBE])
    else $error("egress control single error not recorded");

  // RQ8 parity bit
  a_parity_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ8
    END_TO_END_PARITY_ERR |=> status[B_E2E_PAR])
    else $error("parity error not recorded");

  // RQ9 rising link flag
  a_unrel_rise: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ9
    $rose(UNRELIABLE_LINK_FLAG) |=> status[B_UNREL])
    else $error("unreliable link not recorded");

  // RQ10 replay double
  a_replay_dbe: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ10
    REPLAY_CTRL_DOUBLE_ERR |=> status[B_RP_C_DBE])
    else $error("replay double error not recorded");

  // RQ11 masked bit silent
  a_mask_silent: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ11
    ((status & ~mask_q) == 32'h0000_0000) |=> !REPORT_UNCORRECTABLE && !REPORT_CORRECTABLE)
    else $error("report raised with nothing unmasked");

  // RQ12 sticky bit held without clear
  a_sticky_hold: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ12
    status[B_IN_P_TO] && !wr_status |=> status[B_IN_P_TO])
    else $error("status bit lost without a clear");

  // RQ13 disabled gives no report
  a_enable_gate: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ13
    !report_en |=> !REPORT_UNCORRECTABLE && !REPORT_CORRECTABLE)
    else $error("report while reporting disabled");

  // RQ14 severity picks uncorrectable
  a_sev_uncorr: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ14
    report_en && |(status & ~mask_q & sev_q) |=> REPORT_UNCORRECTABLE)
    else $error("uncorrectable report missing");

  // RQ15 reserved bits zero
  a_reserved_zero: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ15
    ((status | mask_q | sev_q) & ~IMPL_MASK) == 32'h0000_0000)
    else $error("reserved bit set");

  // RQ16 clear of last bit drops report
  sequence s_clear_all;
    wr_status && ((status & ~REG_WDATA) == 32'h0000_0000) && (set_vec == 32'h0000_0000);
  endsequence
  a_clear_drops: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ16
    s_clear_all |=> ##1 !REPORT_UNCORRECTABLE && !REPORT_CORRECTABLE)
    else $error("report stayed after full clear");

  // RQ1 ingress non-posted bit
  a_in_np_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ1
    INGRESS_NONPOSTED_TIMEOUT |=> status[B_IN_NP_TO])
    else $error("ingress non-posted time-out not recorded");

  // RQ1 ingress completion bit
  a_in_c_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ1
    INGRESS_COMPLETION_TIMEOUT |=> status[B_IN_C_TO])
    else $error("ingress completion time-out not recorded");

  // RQ2 egress posted bit
  a_eg_p_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ2
    EGRESS_POSTED_TIMEOUT |=> status[B_EG_P_TO])
    else $error("egress posted time-out not recorded");

  // RQ2 egress non-posted bit
  a_eg_np_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ2
    EGRESS_NONPOSTED_TIMEOUT |=> status[B_EG_NP_TO])
    else $error("egress non-posted time-out not recorded");

  // RQ5 ingress control single
  a_in_csbe_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ5
    INGRESS_CTRL_SINGLE_ERR |=> status[B_IN_C_SBE])
    else $error("ingress control single error not recorded");

  // RQ6 egress data double
  a_eg_ddbe_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ6
    EGRESS_DATA_DOUBLE_ERR |=> status[B_EG_D_DBE])
    else $error("egress data double error not recorded");

  // RQ7 egress control double
  a_eg_cdbe_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ7
    EGRESS_CTRL_DOUBLE_ERR |=> status[B_EG_C_DBE])
    else $error("egress control double error not recorded");

  // RQ10 replay single
  a_replay_sbe: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ10
    REPLAY_CTRL_SINGLE_ERR |=> status[B_RP_C_SBE])
    else $error("replay single error not recorded");

  // RQ1 write of one clears
  sequence s_clear_p_to;
    wr_status && REG_WDATA[B_IN_P_TO] && !INGRESS_POSTED_TIMEOUT;
  endsequence
  a_w1c_clear: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ1
    s_clear_p_to |=> !status[B_IN_P_TO])
    else $error("posted time-out bit not cleared by a write of one");

  // RQ14 severity picks correctable
  a_sev_corr: assert property (@(posedge CLK_SYS) disable iff (RESET) // RQ14
    report_en && |(status & ~mask_q & ~sev_q) |=> REPORT_CORRECTABLE)
    else $error("correctable report missing");
endmodule
`default_nettype wire

/* verif/iesm_evt_model.sv */
// Behavioural model of the buffer error detectors and link reliability logic.
// Assumes requests from the bench arrive as a vector sampled on the clock edge.
`timescale 1ns/1ps
`default_nettype none
module iesm_evt_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [31:0] fire,
  input  wire logic        link_drop,
  output logic      [31:0] evt
);
  import iesm_pkg::*;
  logic [31:0] pulse_q;
  logic        link_q;
  // Detectors send one-cycle pulses; reserved positions are never driven
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_q <= 32'h0000_0000;
    end else begin
      pulse_q <= fire & IMPL_MASK & ~(32'h0000_0001 << B_UNREL);
    end
  end
  // The unreliable-link flag is a level: it stays up until the link recovers
  always_ff @(posedge clk) begin
    if (rst) begin
      link_q <= 1'b0;
    end else if (fire[B_UNREL]) begin
      link_q <= 1'b1;
    end else if (link_drop) begin
      link_q <= 1'b0;
    end
  end
  assign evt = pulse_q | ({31'h0000_0000, link_q} << B_UNREL);
endmodule
`default_nettype wire

/* verif/internal_error_status_mask_tb_top.sv */
// Self-checking bench for the internal error status and mask bank.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module internal_error_status_mask_tb_top;
  import iesm_pkg::*;
  logic        clk;
  logic        rst;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [31:0] fire;
  logic        link_drop;
  logic [31:0] evt;
  logic        rep_unc;
  logic        rep_cor;
  logic        irq;
  int          err_count;
  int          tests_run;
  int          cyc;
  logic [31:0] exp_sts;
  logic [31:0] msk;
  logic [31:0] sev;
  logic        en;
  logic [31:0] v;
  logic [31:0] clr;
  logic [31:0] ev;

  iesm_evt_model u_src (.clk(clk), .rst(rst), .fire(fire), .link_drop(link_drop), .evt(evt));

  iesm_top dut (
    .CLK_SYS(clk), .RESET(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .INGRESS_POSTED_TIMEOUT(evt[0]), .INGRESS_NONPOSTED_TIMEOUT(evt[1]),
    .INGRESS_COMPLETION_TIMEOUT(evt[2]), .EGRESS_POSTED_TIMEOUT(evt[4]),
    .EGRESS_NONPOSTED_TIMEOUT(evt[5]), .EGRESS_COMPLETION_TIMEOUT(evt[6]),
    .INGRESS_DATA_SINGLE_ERR(evt[7]), .INGRESS_DATA_DOUBLE_ERR(evt[8]),
    .INGRESS_CTRL_SINGLE_ERR(evt[9]), .INGRESS_CTRL_DOUBLE_ERR(evt[10]),
    .EGRESS_DATA_SINGLE_ERR(evt[11]), .EGRESS_DATA_DOUBLE_ERR(evt[12]),
    .EGRESS_CTRL_SINGLE_ERR(evt[13]), .EGRESS_CTRL_DOUBLE_ERR(evt[14]),
    .END_TO_END_PARITY_ERR(evt[15]), .UNRELIABLE_LINK_FLAG(evt[16]),
    .REPLAY_CTRL_SINGLE_ERR(evt[17]), .REPLAY_CTRL_DOUBLE_ERR(evt[18]),
    .REPORT_UNCORRECTABLE(rep_unc), .REPORT_CORRECTABLE(rep_cor), .IRQ(irq)
  );

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard: far above the cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  function automatic logic exp_rep(logic [31:0] s, logic [31:0] m, logic [31:0] sv, logic e);
    exp_rep = e & (|(s & ~m & sv));
  endfunction

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is taken in the single cycle after the strobe
  task automatic rd(logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic pulse(logic [31:0] vec);
    @(posedge clk);
    fire <= vec;
    @(posedge clk);
    fire <= 32'h0000_0000;
    repeat (2) @(posedge clk);
  endtask

  // Status, pending view, interrupt and both report lines against the mirror
  task automatic check_all();
    logic [31:0] er;
    er = {30'h0, exp_rep(exp_sts, msk, ~sev, en), exp_rep(exp_sts, msk, sev, en)};
    rd(OFF_STATUS, v);
    chk("status", exp_sts, v);
    rd(OFF_PENDING, v);
    chk("pending", exp_sts & ~msk, v);
    chk("irq", {31'h0, |(exp_sts & ~msk)}, {31'h0, irq});
    chk("uncorr", {31'h0, exp_rep(exp_sts, msk, sev, en)}, {31'h0, rep_unc});
    chk("corr", {31'h0, exp_rep(exp_sts, msk, ~sev, en)}, {31'h0, rep_cor});
    rd(OFF_REPORT, v);
    chk("report reg", er, v);
  endtask

  task automatic print_verdict();
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fire = 32'h0000_0000;
    link_drop = 1'b0;
    err_count = 0;
    tests_run = 0;
    cyc = 0;
    exp_sts = RST_STATUS;
    msk = RST_MASK;
    sev = RST_SEV;
    en = 1'b1;
    void'($urandom(32'h5BE7));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped place
    rd(OFF_CTRL, v);
    chk("ctrl", 32'h0000_0001, v);
    rd(OFF_MASK, v);
    chk("mask", 32'h0000_0000, v);
    rd(OFF_SEV, v);
    chk("sev", RST_SEV, v);
    wr(12'h400, 32'hFFFF_FFFF);
    rd(12'h400, v);
    chk("unmapped", 32'h0000_0000, v);
    check_all();
    // Each source on its own, then cleared; the held link flag must not re-set
    for (int i = 0; i < 19; i++) begin
      if (i == 3) continue;
      pulse(32'h0000_0001 << i);
      exp_sts = 32'h0000_0001 << i;
      check_all();
      wr(OFF_STATUS, exp_sts);
      exp_sts = 32'h0000_0000;
      check_all();
      @(posedge clk);
      link_drop <= 1'b1;
      @(posedge clk);
      link_drop <= 1'b0;
    end
    // Full mask: reserved bits stay zero, status still records everything
    wr(OFF_MASK, 32'hFFFF_FFFF);
    msk = IMPL_MASK;
    rd(OFF_MASK, v);
    chk("mask rsvd", IMPL_MASK, v);
    pulse(32'hFFFF_FFFF);
    exp_sts = IMPL_MASK;
    check_all();
    wr(OFF_STATUS, 32'hFFFF_FFFF);
    exp_sts = 32'h0000_0000;
    link_drop <= 1'b1;
    wr(OFF_MASK, 32'h0000_0000);
    link_drop <= 1'b0;
    msk = 32'h0000_0000;
    check_all();
    // Reporting disabled, then enabled with the error still pending
    wr(OFF_CTRL, 32'h0000_0000);
    en = 1'b0;
    pulse(32'h0000_0080);
    exp_sts = 32'h0000_0080;
    check_all();
    wr(OFF_CTRL, 32'hFFFF_FFFF);
    en = 1'b1;
    rd(OFF_CTRL, v);
    chk("ctrl rsvd", CTRL_IMPL, v);
    check_all();
    // Event and clear of the same bit at one edge: the event must survive
    @(posedge clk);
    fire <= 32'h0000_0100;
    @(posedge clk);
    fire      <= 32'h0000_0000;
    reg_wr    <= 1'b1;
    reg_addr  <= OFF_STATUS;
    reg_wdata <= 32'h0000_0180;
    @(posedge clk);
    reg_wr <= 1'b0;
    exp_sts = 32'h0000_0100;
    repeat (2) @(posedge clk);
    check_all();
    // Random mask, severity, events and partial clears
    for (int n = 0; n < 16; n++) begin
      msk = $urandom & IMPL_MASK;
      sev = $urandom & IMPL_MASK;
      wr(OFF_MASK, msk);
      wr(OFF_SEV, sev);
      rd(OFF_MASK, v);
      chk("mask rw", msk, v);
      rd(OFF_SEV, v);
      chk("sev rw", sev, v);
      ev = $urandom & IMPL_MASK & ~(32'h0000_0001 << B_UNREL);
      pulse(ev);
      exp_sts = exp_sts | ev;
      check_all();
      clr = $urandom;
      wr(OFF_STATUS, clr);
      exp_sts = exp_sts & ~clr;
      check_all();
    end
    print_verdict();
  end

endmodule
`default_nettype wire
